/* design/line_diag_pkg.sv */
// constants and types shared by the diagnostic loopback controller, its checker and its bench
// assumes both ends run on one 25 MHz system clock with a synchronous active-low reset
package line_diag_pkg;

    // ************************************************************
    // clock and timing
    // ************************************************************
    localparam int unsigned CLOCK_HZ         = 25_000_000;       // system clock rate
    localparam int unsigned RESET_HOLD_NS    = 40;               // pin reset hold, one cycle
    localparam int unsigned RESET_HOLD_CYC   =
        ((RESET_HOLD_NS * (CLOCK_HZ / 1_000_000)) + 999) / 1000; // rounded up to cycles
    localparam int unsigned TXCLK_LOST_CYC   = 16;               // no tx clock edge this long

    // ************************************************************
    // three-level pin codes
    // ************************************************************
    localparam logic [1:0] PIN_LOW  = 2'h0;                      // driven low
    localparam logic [1:0] PIN_HIGH = 2'h1;                      // driven high
    localparam logic [1:0] PIN_OPEN = 2'h2;                      // left unconnected

    // ************************************************************
    // host register map (own offsets)
    // ************************************************************
    localparam logic [3:0] REG_CTRL2   = 4'h2;                   // loop and all-ones enables
    localparam logic [3:0] REG_CTRL1   = 4'h1;                   // jitter attenuator select
    localparam logic [3:0] REG_ICLR    = 4'h3;                   // interrupt clear and mask
    localparam logic [3:0] REG_STATUS  = 4'h4;                   // sticky event status
    localparam logic [3:0] REG_MODE    = 4'h5;                   // resolved path, read only

    // control register 2 bit positions
    localparam int unsigned BIT_LOCAL   = 0;                     // local_loop_enable_bit
    localparam int unsigned BIT_ANALOG  = 1;                     // analog_loop_enable_bit
    localparam int unsigned BIT_REMOTE  = 2;                     // remote_loop_enable_bit
    localparam int unsigned BIT_ALLONES = 3;                     // all_ones_enable_bit
    localparam int unsigned BIT_RESET   = 4;                     // soft reset

    // interrupt clear bits: maskable sources only
    localparam int unsigned ICLR_WIDTH  = 6;                     // pattern,los,ais,drv,es,bist
    localparam logic [7:0]  CTRL_RESET  = 8'h00;                 // reset value of both control registers

    // ************************************************************
    // resolved diagnostic path
    // ************************************************************
    typedef enum logic [4:0] {
        PATH_NORMAL = 5'h01,
        PATH_LOCAL  = 5'h02,
        PATH_REMOTE = 5'h04,
        PATH_DUAL   = 5'h08,
        PATH_ANALOG = 5'h10
    } path_t;

endpackage

/* design/line_diag_if.sv */
// carrier joining the diagnostic controller (device end) and its host end
// assumes the bench supplies clock and reset and resolves the line tri-state
`timescale 1ns/1ps
interface line_diag_if;
    logic       host_mode;           // 1 host control, 0 hardware pins
    logic [1:0] local_loop_pin;      // three-level pin code
    logic [1:0] analog_loop_pin;     // open commands analog loop
    logic [1:0] remote_loop_pin;
    logic [1:0] all_ones_pin;
    logic [1:0] jitter_atten_pin;    // high rx, low tx, open off
    logic [3:0] addr;                // register address
    logic [7:0] wdata;               // write data
    logic       wr;                  // write strobe
    logic       rd;                  // read strobe
    logic [7:0] rdata;               // read data, cycle after rd
    logic       irq;                 // diagnostic interrupt

    modport device (input host_mode, local_loop_pin, analog_loop_pin, remote_loop_pin,
                    all_ones_pin, jitter_atten_pin, addr, wdata, wr, rd,
                    output rdata, irq);
    modport host   (output host_mode, local_loop_pin, analog_loop_pin, remote_loop_pin,
                    all_ones_pin, jitter_atten_pin, addr, wdata, wr, rd,
                    input rdata, irq);
endinterface

/* design/line_diag_loopback_ctrl.sv */
// device end: resolves diagnostic mode and steers the tx/rx data paths
// assumes line and framer signals are asynchronous and are synchronised here
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ps
module line_diag_loopback_ctrl (
    input  wire logic       clock_in,              // master clock
    input  wire logic       reset_n_in,            // synchronous active-low reset
    line_diag_if.device     ctl,                   // pins and host registers
    input  wire logic       tx_clock_in,           // framer transmit clock
    input  wire logic [1:0] tx_dual_rail_data_in,  // framer transmit data
    input  wire logic       rx_recovered_clock_in, // clock recovered from line
    input  wire logic [1:0] line_rx_pair_in,       // sliced line receive data
    input  wire logic       bipolar_violation_insert_in, // request edge
    input  wire logic [5:0] int_event_in,          // maskable event sources
    output logic            tx_clock_sync_out,     // synchronised tx clock level, for the bench
    output logic [1:0]      rx_dual_rail_data_out, // to framer
    output logic            rx_clock_out,          // to framer: recovered clock, or tx clock in local, dual and analog loops
    output logic [1:0]      line_tx_pair_out,      // to line driver
    output logic            line_tx_oe_out,        // high while driving the line
    output logic            line_rx_connect_out,   // receiver tied to line
    output logic            jitter_atten_loop_out, // attenuator in loop path
    output logic            jitter_atten_rx_out,   // attenuator in rx path
    output logic            bipolar_violation_insert_out, // accepted insert pulse
    output logic            host_only_enable_out,  // violation/alarm/bist monitors on
    output logic            device_reset_out       // internal reset request
);

    // ************************************************************
    // state record
    // ************************************************************
    typedef struct packed {
        logic [6:0] s1;          // first sync stage of 7 async input bits
        logic [6:0] s2;          // second sync stage
        logic       txc_d;       // last tx clock level
        logic [4:0] lost;        // cycles without tx clock edge
        logic       insv_d;      // last insert request level
        logic [9:0] p1;          // pin sync stage one
        logic [9:0] p2;          // pin sync stage two
        logic [7:0] ctrl1;       // jitter attenuator select bits
        logic [7:0] ctrl2;       // loop enable bits
        logic [5:0] iclr;        // interrupt mask bits
        logic [5:0] pend;        // sticky events
        logic [7:0] rdata;       // read data
        logic       irq;
        line_diag_pkg::path_t path;
        logic       ones;
        logic [1:0] rxd;
        logic       rxc;
        logic [1:0] txd;
        logic       oe;
        logic       rxcon;
        logic       jitter_atten_loop;
        logic       jarx;
        logic       ins;
        logic       honly;
        logic       rst;
    } state_t;

    state_t st;                  // registered state
    state_t next_st;             // next state

    // ************************************************************
    // decode helpers
    // ************************************************************
    // true when a pin code is driven high
    function automatic logic is_high(input logic [1:0] code);
        return code == line_diag_pkg::PIN_HIGH;
    endfunction

    // true when a pin code is left open
    function automatic logic is_open(input logic [1:0] code);
        return code == line_diag_pkg::PIN_OPEN;
    endfunction

    // ************************************************************
    // next-state logic
    // ************************************************************
    logic loc;                   // local loop request
    logic ana;                   // analog loop request
    logic rem;                   // remote loop request
    logic aon;                   // all-ones request
    logic ja_on;                 // attenuator enabled
    logic ja_rx;                 // attenuator placed in rx path
    logic txc_seen;              // tx clock present
    logic [1:0] tx_src;          // data the transmitter sends

    always_comb begin
        next_st = st;
        // two-flop synchronisers for line side clocks and data
        next_st.s1 = {bipolar_violation_insert_in, tx_dual_rail_data_in, tx_clock_in,
                      rx_recovered_clock_in, line_rx_pair_in};
        next_st.s2 = st.s1;
        next_st.p1 = {ctl.local_loop_pin, ctl.analog_loop_pin, ctl.remote_loop_pin,
                      ctl.all_ones_pin, ctl.jitter_atten_pin};
        next_st.p2 = st.p1;
        next_st.txc_d  = st.s2[3];
        next_st.insv_d = st.s2[6];
        // tx clock watchdog
        if (st.s2[3] != st.txc_d) begin
            next_st.lost = '0;
        end else if (st.lost != 5'(line_diag_pkg::TXCLK_LOST_CYC)) begin
            next_st.lost = st.lost + 5'h1;
        end
        txc_seen = st.lost != 5'(line_diag_pkg::TXCLK_LOST_CYC);

        // mode source: pins or host bits
        if (ctl.host_mode) begin
            loc   = st.ctrl2[line_diag_pkg::BIT_LOCAL];
            ana   = st.ctrl2[line_diag_pkg::BIT_ANALOG];
            rem   = st.ctrl2[line_diag_pkg::BIT_REMOTE];
            aon   = st.ctrl2[line_diag_pkg::BIT_ALLONES];
            ja_on = st.ctrl1[0];
            ja_rx = st.ctrl1[1];
        end else begin
            loc   = is_high(st.p2[9:8]);
            ana   = is_open(st.p2[7:6]);
            rem   = is_high(st.p2[5:4]);
            aon   = is_high(st.p2[3:2]);
            ja_on = !is_open(st.p2[1:0]);
            ja_rx = is_high(st.p2[1:0]);
        end

        // loop resolution
        if (ana) begin
            next_st.path = line_diag_pkg::PATH_ANALOG;
        end else if (rem && loc) begin
            next_st.path = line_diag_pkg::PATH_DUAL;
        end else if (rem) begin
            next_st.path = line_diag_pkg::PATH_REMOTE;
        end else if (loc) begin
            next_st.path = line_diag_pkg::PATH_LOCAL;
        end else begin
            next_st.path = line_diag_pkg::PATH_NORMAL;
        end
        next_st.ones = aon && !rem;

        // data path steering
        tx_src = next_st.ones ? 2'h3 : st.s2[5:4];
        next_st.rxcon = 1'b1;
        next_st.jitter_atten_loop   = 1'b0;
        next_st.jarx  = ja_on && ja_rx;
        case (st.path)
            line_diag_pkg::PATH_LOCAL, line_diag_pkg::PATH_DUAL: begin
                next_st.rxcon = 1'b0;
                next_st.jitter_atten_loop   = ja_on;
                next_st.jarx  = 1'b0;
                next_st.rxd   = st.s2[5:4];
                next_st.rxc   = st.s2[3];
            end
            line_diag_pkg::PATH_ANALOG: begin
                next_st.rxcon = 1'b0;
                next_st.rxd   = st.txd;
                next_st.rxc   = st.s2[3];
            end
            default: begin
                next_st.rxd = st.s2[1:0];
                next_st.rxc = st.s2[2];
            end
        endcase
        case (st.path)
            line_diag_pkg::PATH_REMOTE, line_diag_pkg::PATH_DUAL: begin
                next_st.txd = st.s2[1:0];
                next_st.oe  = 1'b1;
            end
            default: begin
                next_st.txd = tx_src;
                next_st.oe  = txc_seen || next_st.ones;
            end
        endcase
        // bipolar violation insert, rising edge, not in remote loop
        next_st.ins = st.s2[6] && !st.insv_d && !rem;
        next_st.honly = ctl.host_mode;

        // host register port
        next_st.rdata = '0;
        if (ctl.wr && ctl.host_mode) begin
            case (ctl.addr)
                line_diag_pkg::REG_CTRL1: next_st.ctrl1 = ctl.wdata;
                line_diag_pkg::REG_CTRL2: next_st.ctrl2 = ctl.wdata;
                line_diag_pkg::REG_ICLR:  next_st.iclr  = ctl.wdata[5:0];
                default: ;
            endcase
        end
        if (ctl.rd) begin
            case (ctl.addr)
                line_diag_pkg::REG_CTRL1:  next_st.rdata = st.ctrl1;
                line_diag_pkg::REG_CTRL2:  next_st.rdata = st.ctrl2;
                line_diag_pkg::REG_ICLR:   next_st.rdata = {2'h0, st.iclr};
                line_diag_pkg::REG_STATUS: next_st.rdata = {2'h0, st.pend};
                line_diag_pkg::REG_MODE:   next_st.rdata = {3'h0, st.path};
                default:                   next_st.rdata = 8'h00;
            endcase
        end
        // sticky events: clear bit clears and masks; clear wins over a new event
        if (ctl.host_mode) begin
            next_st.pend = (st.pend & ~next_st.iclr) | (int_event_in & ~next_st.iclr);
        end else begin
            next_st.pend = '0;
        end
        next_st.irq = |st.pend;
        // pin reset and soft reset
        next_st.rst = (!ctl.host_mode && loc && rem && aon)
                    || (ctl.host_mode && st.ctrl2[line_diag_pkg::BIT_RESET]);
        if (st.rst) begin
            next_st.ctrl1 = line_diag_pkg::CTRL_RESET;
            next_st.ctrl2 = line_diag_pkg::CTRL_RESET;
            next_st.iclr  = '0;
            next_st.pend  = '0;
        end
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            st      <= '0;
            st.path <= line_diag_pkg::PATH_NORMAL;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from flip-flops
    assign tx_clock_sync_out            = st.txc_d;
    assign rx_dual_rail_data_out        = st.rxd;
    assign rx_clock_out                 = st.rxc;
    assign line_tx_pair_out             = st.txd;
    assign line_tx_oe_out               = st.oe;
    assign line_rx_connect_out          = st.rxcon;
    assign jitter_atten_loop_out        = st.jitter_atten_loop;
    assign jitter_atten_rx_out          = st.jarx;
    assign bipolar_violation_insert_out = st.ins;
    assign host_only_enable_out         = st.honly;
    assign device_reset_out             = st.rst;
    assign ctl.rdata                    = st.rdata;
    assign ctl.irq                      = st.irq;

endmodule // line_diag_loopback_ctrl

/* design/line_diag_host.sv */
// host end: drives mode pins or host registers from a user command port
// assumes the device end sits on the same clock behind line_diag_if
`timescale 1ns/1ps
module line_diag_host (
    input  wire logic       clock_in,        // system clock
    input  wire logic       reset_n_in,      // synchronous active-low reset
    line_diag_if.host       ctl,             // pins and register bus to device
    input  wire logic       host_mode_in,    // select host control
    input  wire logic [1:0] local_pin_in,    // pin codes for hardware mode
    input  wire logic [1:0] analog_pin_in,
    input  wire logic [1:0] remote_pin_in,
    input  wire logic [1:0] all_ones_pin_in,
    input  wire logic [1:0] jitter_pin_in,
    input  wire logic [3:0] addr_in,         // register access request
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    output logic [7:0]      rdata_out,       // read answer, three cycles after rd_in
    output logic            irq_out          // device interrupt, registered
);

    // ************************************************************
    // state record
    // ************************************************************
    typedef struct packed {
        logic       mode;
        logic [9:0] pins;
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
        logic       rd_d;
        logic [7:0] rdata;
        logic       irq;
    } state_t;

    state_t st;                              // registered state
    state_t next_st;                         // next state

    // registered copies of the user requests; write dropped when a read is asked at once
    always_comb begin
        next_st       = st;
        next_st.mode  = host_mode_in;
        next_st.pins  = {local_pin_in, analog_pin_in, remote_pin_in,
                         all_ones_pin_in, jitter_pin_in};
        next_st.addr  = addr_in;
        next_st.wdata = wdata_in;
        next_st.wr    = wr_in && !rd_in;
        next_st.rd    = rd_in;
        next_st.rd_d  = st.rd;
        next_st.rdata = st.rd_d ? ctl.rdata : st.rdata;
        next_st.irq   = ctl.irq;
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign ctl.host_mode        = st.mode;
    assign ctl.local_loop_pin   = st.pins[9:8];
    assign ctl.analog_loop_pin  = st.pins[7:6];
    assign ctl.remote_loop_pin  = st.pins[5:4];
    assign ctl.all_ones_pin     = st.pins[3:2];
    assign ctl.jitter_atten_pin = st.pins[1:0];
    assign ctl.addr             = st.addr;
    assign ctl.wdata            = st.wdata;
    assign ctl.wr               = st.wr;
    assign ctl.rd               = st.rd;
    assign rdata_out            = st.rdata;
    assign irq_out              = st.irq;

endmodule // line_diag_host

/* bench/line_diag_chk.sv */
// checker: timing relations on the carrier between the host end and the device end
// assumes one system clock and one synchronous active-low reset for both ends
`timescale 1ns/1ps
module line_diag_chk (
    input wire logic       clock_in,        // system clock
    input wire logic       reset_n_in,      // synchronous reset, low active
    input wire logic       host_mode,       // control mode
    input wire logic [1:0] local_loop_pin,  // pin codes
    input wire logic [1:0] analog_loop_pin,
    input wire logic [1:0] remote_loop_pin,
    input wire logic [1:0] all_ones_pin,
    input wire logic [3:0] addr,            // register bus
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic       irq
);
    // ************************************************************
    // path that the pins ask for
    // ************************************************************
    logic [4:0] pin_path;                   // expected one-hot path
    logic       pin_reset;                  // reset combination on the pins
    logic       lh;                         // local loop pin high
    logic       rh;                         // remote loop pin high
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);
    // analog beats dual, dual beats the single loops
    always_comb begin
        lh = local_loop_pin == line_diag_pkg::PIN_HIGH;
        rh = remote_loop_pin == line_diag_pkg::PIN_HIGH;
        pin_reset = lh && rh && (all_ones_pin == line_diag_pkg::PIN_HIGH);
        if (analog_loop_pin == line_diag_pkg::PIN_OPEN) begin
            pin_path = line_diag_pkg::PATH_ANALOG;
        end else if (lh && rh) begin
            pin_path = line_diag_pkg::PATH_DUAL;
        end else if (rh) begin
            pin_path = line_diag_pkg::PATH_REMOTE;
        end else if (lh) begin
            pin_path = line_diag_pkg::PATH_LOCAL;
        end else begin
            pin_path = line_diag_pkg::PATH_NORMAL;
        end
    end
    // ************************************************************
    // properties
    // ************************************************************
    sequence hw_held;
        !host_mode [*8];
    endsequence
    sequence pins_held;
        (!host_mode && !pin_reset && $stable(pin_path)) [*8];
    endsequence
    mode_from_pins_a: assert property (
        pins_held ##0 (rd && addr == line_diag_pkg::REG_MODE) |=> rdata == {3'h0, $past(pin_path)})
        else $error("mode read does not match the pins");
    hw_no_irq_a: assert property (hw_held |-> !irq)
        else $error("interrupt raised in hardware mode");
    hw_status_zero_a: assert property (
        hw_held ##0 (rd && addr == line_diag_pkg::REG_STATUS) |=> rdata == 8'h00)
        else $error("status not empty in hardware mode");
    read_one_cycle_a: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data outside its cycle");
    unmapped_read_a: assert property (
        (rd && (addr == 4'h0 || addr > 4'h5)) |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    single_strobe_a: assert property (!(wr && rd))
        else $error("both strobes at once");
    reset_quiet_a: assert property ($rose(reset_n_in) |-> (rdata == 8'h00 && !irq))
        else $error("outputs not cleared by reset");
    mask_clears_a: assert property (
        (host_mode && wr && addr == line_diag_pkg::REG_ICLR && wdata[5:0] == 6'h3f)
        |-> ##[1:6] !irq)
        else $error("interrupt not cleared by mask write");
endmodule // line_diag_chk

/* bench/line_diag_loopback_ctrl_bench.sv */
// bench: host end and device end joined by the carrier, driven from the host user side
// assumes the design package and carrier are compiled first
`timescale 1ns/1ps
module line_diag_loopback_ctrl_bench;
    localparam logic [1:0] LO = line_diag_pkg::PIN_LOW;   // pin code aliases
    localparam logic [1:0] HI = line_diag_pkg::PIN_HIGH;
    localparam logic [1:0] OP = line_diag_pkg::PIN_OPEN;
    logic clock_in, reset_n_in, host_mode_in, wr_in, rd_in, irq_out, tx_run;
    logic tx_clock_in, rx_recovered_clock_in, bipolar_violation_insert_in;
    logic [1:0] local_pin_in, analog_pin_in, remote_pin_in, all_ones_pin_in, jitter_pin_in;
    logic [1:0] tx_dual_rail_data_in, line_rx_pair_in, rx_dual_rail_data_out, line_tx_pair_out;
    logic [3:0] addr_in;
    logic [7:0] wdata_in, rdata_out, d;
    logic [5:0] int_event_in;
    logic tx_clock_sync_out, rx_clock_out, line_tx_oe_out, line_rx_connect_out;
    logic jitter_atten_loop_out, jitter_atten_rx_out, bipolar_violation_insert_out;
    logic host_only_enable_out, device_reset_out;
    int   error_cnt, total_checks;
    line_diag_if bus ();
    line_diag_loopback_ctrl line_diag_loopback_ctrl_inst (.clock_in, .reset_n_in, .ctl(bus),
        .tx_clock_in, .tx_dual_rail_data_in, .rx_recovered_clock_in, .line_rx_pair_in,
        .bipolar_violation_insert_in, .int_event_in, .tx_clock_sync_out, .rx_dual_rail_data_out,
        .rx_clock_out, .line_tx_pair_out, .line_tx_oe_out, .line_rx_connect_out,
        .jitter_atten_loop_out, .jitter_atten_rx_out, .bipolar_violation_insert_out,
        .host_only_enable_out, .device_reset_out);
    line_diag_host line_diag_host_inst (.clock_in, .reset_n_in, .ctl(bus), .host_mode_in,
        .local_pin_in, .analog_pin_in, .remote_pin_in, .all_ones_pin_in, .jitter_pin_in,
        .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .irq_out);
    line_diag_chk line_diag_chk_inst (.clock_in, .reset_n_in, .host_mode(bus.host_mode),
        .local_loop_pin(bus.local_loop_pin), .analog_loop_pin(bus.analog_loop_pin),
        .remote_loop_pin(bus.remote_loop_pin), .all_ones_pin(bus.all_ones_pin),
        .addr(bus.addr), .wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd), .rdata(bus.rdata),
        .irq(bus.irq));
    // ************************************************************
    // clocks: system, gated framer clock, free line clock
    // ************************************************************
    initial begin clock_in = 1'b0; forever #20 clock_in = ~clock_in; end
    initial begin tx_clock_in = 1'b0; #7; forever #160 tx_clock_in = tx_run & ~tx_clock_in; end
    initial begin rx_recovered_clock_in = 1'b0; #53;
        forever #160 rx_recovered_clock_in = ~rx_recovered_clock_in; end
    // ************************************************************
    // tasks
    // ************************************************************
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n); repeat (n) @(posedge clock_in); #1; endtask
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clock_in); addr_in <= a; wdata_in <= v; wr_in <= 1'b1;
        @(posedge clock_in); wr_in <= 1'b0;
    endtask
    // host answer stands from the second edge after the strobe is taken
    task automatic reg_rd(input logic [3:0] a);
        @(posedge clock_in); addr_in <= a; rd_in <= 1'b1;
        @(posedge clock_in); rd_in <= 1'b0;
        tick(4); d = rdata_out;
    endtask
    task automatic pulse(input logic [5:0] m);
        @(posedge clock_in); int_event_in <= m;
        @(posedge clock_in); int_event_in <= 6'h00;
    endtask
    // set pins, let them settle, compare path and line drive, or receiver connect in analog loop
    task automatic hw_case(input logic [1:0] l, a, r, o,
                           input line_diag_pkg::path_t p, input logic oe);
        @(posedge clock_in); local_pin_in <= l; analog_pin_in <= a;
        remote_pin_in <= r; all_ones_pin_in <= o;
        tick(24); reg_rd(line_diag_pkg::REG_MODE); chk("mode", {3'h0, p}, d);
        if (p == line_diag_pkg::PATH_ANALOG) chk("rx connect", 8'h00, {7'h0, line_rx_connect_out});
        else chk("line oe", {7'h0, oe}, {7'h0, line_tx_oe_out});
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin #400000; error_cnt++; final_report(); end
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        {reset_n_in, host_mode_in, wr_in, rd_in, tx_run, bipolar_violation_insert_in} = 6'h00;
        {local_pin_in, analog_pin_in, remote_pin_in, all_ones_pin_in, jitter_pin_in} = 10'h000;
        {tx_dual_rail_data_in, line_rx_pair_in, addr_in, wdata_in, int_event_in} = 22'h0;
        repeat (3) @(posedge clock_in); reset_n_in <= 1'b1;
        reg_wr(line_diag_pkg::REG_CTRL2, 8'h01);                  // write ignored in hardware mode
        hw_case(LO, LO, LO, LO, line_diag_pkg::PATH_NORMAL, 1'b0);
        hw_case(HI, LO, LO, LO, line_diag_pkg::PATH_LOCAL, 1'b0);
        hw_case(LO, LO, HI, LO, line_diag_pkg::PATH_REMOTE, 1'b1);
        hw_case(HI, LO, HI, LO, line_diag_pkg::PATH_DUAL, 1'b1);
        hw_case(HI, OP, HI, LO, line_diag_pkg::PATH_ANALOG, 1'b0);
        hw_case(LO, LO, LO, HI, line_diag_pkg::PATH_NORMAL, 1'b1);
        chk("ones data", 8'h03, {6'h0, line_tx_pair_out});
        tx_run = 1'b1;
        hw_case(LO, LO, LO, LO, line_diag_pkg::PATH_NORMAL, 1'b1);
        @(posedge clock_in); host_mode_in <= 1'b1;
        reg_rd(line_diag_pkg::REG_CTRL2); chk("hw write", 8'h00, d);
        reg_wr(line_diag_pkg::REG_CTRL2, 8'h05);                  // local and remote enable bits
        tick(8); reg_rd(line_diag_pkg::REG_MODE); chk("host dual", 8'h08, d);
        reg_wr(line_diag_pkg::REG_CTRL2, 8'h07);                  // analog added on top
        tick(8); reg_rd(line_diag_pkg::REG_MODE); chk("host analog", 8'h10, d);
        reg_wr(line_diag_pkg::REG_CTRL2, 8'h00);
        pulse(6'h02); tick(6); chk("irq raised", 8'h01, {7'h0, irq_out});
        reg_wr(line_diag_pkg::REG_ICLR, 8'h3f); tick(6);
        chk("irq cleared", 8'h00, {7'h0, irq_out});
        pulse(6'h02); tick(6); chk("irq masked", 8'h00, {7'h0, irq_out});
        reg_wr(line_diag_pkg::REG_ICLR, 8'h00); reg_rd(4'hf); chk("unmapped", 8'h00, d);
        @(posedge clock_in); host_mode_in <= 1'b0;
        tick(12); pulse(6'h21); tick(6); chk("hw irq", 8'h00, {7'h0, irq_out});
        reg_rd(line_diag_pkg::REG_STATUS); chk("hw status", 8'h00, d);
        chk("host only", 8'h00, {7'h0, host_only_enable_out});
        @(posedge clock_in); local_pin_in <= HI; remote_pin_in <= HI; all_ones_pin_in <= HI;
        tick(8); chk("pin reset", 8'h01, {7'h0, device_reset_out});
        final_report();
    end
endmodule // line_diag_loopback_ctrl_bench
